// ---- dct_pkg.sv ----
// package with register map, field positions and mode codes for the dual counter/timer
package dct_pkg;
    // register byte addresses on the ahb-lite bus
    localparam logic [7:0] DCT_TL0_OFS = 8'h00;  // timer_zero_low_count
    localparam logic [7:0] DCT_TH0_OFS = 8'h04;  // timer_zero_high_count
    localparam logic [7:0] DCT_TL1_OFS = 8'h08;  // timer_one_low_count
    localparam logic [7:0] DCT_TH1_OFS = 8'h0c;  // timer_one_high_count
    localparam logic [7:0] DCT_TIMER_CONTROL_STATUS_REG_OFS = 8'h10; // timer_control_status_reg
    localparam logic [7:0] DCT_TIMER_MODE_REG_OFS = 8'h14; // timer_mode_reg
    localparam logic [7:0] DCT_CLOCK_CONTROL_REG_OFS = 8'h18; // clock_control_reg
    localparam logic [7:0] DCT_IRQ_OFS = 8'h1c;  // irq enables, polarities, vector acks
    // control/status field positions
    localparam int DCT_TF1_BIT = 7;
    localparam int DCT_TR1_BIT = 6;
    localparam int DCT_TF0_BIT = 5;
    localparam int DCT_TR0_BIT = 4;
    // mode register field positions
    localparam int DCT_TIMER_ONE_GATE_BIT_BIT = 7;
    localparam int DCT_CT1_BIT = 6;
    localparam int DCT_M1_LSB = 4;
    localparam int DCT_TIMER_ZERO_GATE_BIT_BIT = 3;
    localparam int DCT_CT0_BIT = 2;
    localparam int DCT_M0_LSB = 0;
    // clock control field positions
    localparam int DCT_CS1_BIT = 3;
    localparam int DCT_CS0_BIT = 2;
    localparam int DCT_SCA_LSB = 0;
    // irq register field positions
    localparam int DCT_ET0_BIT = 0;
    localparam int DCT_ET1_BIT = 1;
    localparam int DCT_PL0_BIT = 2;
    localparam int DCT_PL1_BIT = 3;
    localparam int DCT_ACK0_BIT = 4;
    localparam int DCT_ACK1_BIT = 5;
    // reset value of every register
    localparam logic [7:0] DCT_RESET_VAL = 8'h00;
    // prescaler divide counts
    localparam logic [5:0] DCT_DIV12 = 6'd12;
    localparam logic [5:0] DCT_DIV4 = 6'd4;
    localparam logic [5:0] DCT_DIV48 = 6'd48;
    localparam logic [5:0] DCT_DIV8 = 6'd8;
    // mode codes
    localparam logic [1:0] DCT_MODE13 = 2'b00;
    localparam logic [1:0] DCT_MODE16 = 2'b01;
    localparam logic [1:0] DCT_MODE8AR = 2'b10;
    localparam logic [1:0] DCT_MODESPLIT = 2'b11;
    // prescale codes
    localparam logic [1:0] DCT_SCA12 = 2'b00;
    localparam logic [1:0] DCT_SCA4 = 2'b01;
    localparam logic [1:0] DCT_SCA48 = 2'b10;
    localparam logic [1:0] DCT_SCAEXT = 2'b11;
    // ahb transfer type for a valid request
    localparam logic [1:0] DCT_HTRANS_NONSEQ = 2'b10;
    // bus slave phase
    typedef enum logic [0:0] {DCT_IDLE, DCT_DATA} dct_phase_e;
endpackage : dct_pkg

// ---- dct_prescaler.sv ----
// shared prescaler producing one tick per divided period
`timescale 1ns/1ps
`default_nettype none
module dct_prescaler
    import dct_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [1:0] sca_i,      // shared_prescale_field
    input wire logic ext_clk_i,        // external clock, already synchronised
    output logic tick_o                // one-cycle prescaled tick
);
    logic [5:0] cnt_reg;   // divide counter
    logic [5:0] cnt_next;
    logic ext_d_reg;       // previous external clock level
    logic [5:0] limit;     // divide ratio for the code
    logic step;            // counter advances

    // the external source counts rising edges, the others each clock
    assign limit = (sca_i == DCT_SCA12) ? DCT_DIV12 :
                   (sca_i == DCT_SCA4) ? DCT_DIV4 :
                   (sca_i == DCT_SCA48) ? DCT_DIV48 : DCT_DIV8;
    assign step = (sca_i == DCT_SCAEXT) ? (ext_clk_i & ~ext_d_reg) : 1'b1;
    assign tick_o = step && (cnt_reg >= limit - 6'd1);
    assign cnt_next = tick_o ? 6'd0 : (step ? cnt_reg + 6'd1 : cnt_reg);

    // counter and edge history
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= 6'd0;
            ext_d_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            ext_d_reg <= ext_clk_i;
        end
    end
endmodule : dct_prescaler
`default_nettype wire

// ---- dct_timers.sv ----
// dual counter/timer with four modes behind an ahb-lite slave
//
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module dct_timers
    import dct_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [7:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic timer_zero_count_pin_i,
    input wire logic timer_one_count_pin_i,
    input wire logic ext_irq_input_zero_i,
    input wire logic ext_irq_input_one_i,
    input wire logic ext_clk_i,
    output logic timer_zero_irq_o,
    output logic timer_one_irq_o,
    output logic timer_one_overflow_o       // raw overflow pulse for baud consumers
);
    // registers
    logic [7:0] tl0_reg, th0_reg, tl1_reg, th1_reg;   // count bytes
    logic [7:0] tl0_next, th0_next, tl1_next, th1_next;
    logic [7:0] timer_control_status_reg_reg, timer_mode_reg_reg, clock_control_reg_reg, irqc_reg; // control
    logic [7:0] timer_control_status_reg_next;
    dct_phase_e phase_reg;      // ahb data phase pending
    logic [7:0] addr_reg;       // latched address
    logic wr_reg;               // latched write
    logic [31:0] rdata_reg;     // read data
    // synchronisers: first stage read only by second
    logic [3:0] sync1_reg, sync2_reg, prev_reg;
    logic ov_reg;               // registered timer one raw overflow pulse

    // address phase accepted
    wire req = hsel_i && hready_i && htrans_i == DCT_HTRANS_NONSEQ;
    wire wen = phase_reg == DCT_DATA && wr_reg;
    wire [7:0] wb = hwdata_i[7:0];
    wire w_tl0 = wen && addr_reg == DCT_TL0_OFS;
    wire w_th0 = wen && addr_reg == DCT_TH0_OFS;
    wire w_tl1 = wen && addr_reg == DCT_TL1_OFS;
    wire w_th1 = wen && addr_reg == DCT_TH1_OFS;
    wire w_timer_control_status_reg = wen && addr_reg == DCT_TIMER_CONTROL_STATUS_REG_OFS;

    // decoded fields
    wire [1:0] m0 = timer_mode_reg_reg[DCT_M0_LSB +: 2];
    wire [1:0] m1 = timer_mode_reg_reg[DCT_M1_LSB +: 2];
    wire split = m0 == DCT_MODESPLIT;
    wire tr0 = timer_control_status_reg_reg[DCT_TR0_BIT];
    wire tr1 = timer_control_status_reg_reg[DCT_TR1_BIT];
    // synchronised inputs: 0 pin0, 1 pin1, 2 irq0, 3 irq1 ... ext clock separate
    wire pin0_fall = prev_reg[0] & ~sync2_reg[0];
    wire pin1_fall = prev_reg[1] & ~sync2_reg[1];
    wire irq0_act = sync2_reg[2] ~^ irqc_reg[DCT_PL0_BIT];  // active at polarity
    wire irq1_act = sync2_reg[3] ~^ irqc_reg[DCT_PL1_BIT];
    logic ext_s1_reg, ext_s2_reg;
    wire pre_tick;

    // prescaled tick shared by both timers
    dct_prescaler dct_prescaler_i (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sca_i(clock_control_reg_reg[DCT_SCA_LSB +: 2]),
        .ext_clk_i(ext_s2_reg),
        .tick_o(pre_tick)
    );

    // internal clock: 1 system clock, 0 prescaler
    wire clk0 = clock_control_reg_reg[DCT_CS0_BIT] ? 1'b1 : pre_tick;
    wire clk1 = clock_control_reg_reg[DCT_CS1_BIT] ? 1'b1 : pre_tick;
    // gate: run and (no gate or input active)
    wire en0 = tr0 && (!timer_mode_reg_reg[DCT_TIMER_ZERO_GATE_BIT_BIT] || irq0_act);
    wire en1n = tr1 && (!timer_mode_reg_reg[DCT_TIMER_ONE_GATE_BIT_BIT] || irq1_act);
    // timer one in split runs by mode, internal only; mode 3 always stops it
    wire en1 = (m1 != DCT_MODESPLIT) && (split || en1n);
    wire ev0 = en0 && (timer_mode_reg_reg[DCT_CT0_BIT] ? pin0_fall : clk0);
    wire ev1 = en1 && ((timer_mode_reg_reg[DCT_CT1_BIT] && !split) ? pin1_fall : clk1);
    wire evh = split && tr1 && clk0;

    // step one timer: returns {overflow, high, low}
    function automatic logic [16:0] dct_step(input logic [1:0] mode, input logic [7:0] lo,
                                             input logic [7:0] hi);
        logic [12:0] c13;
        logic [16:0] c16;
        logic [8:0] c8;
        c13 = {hi, lo[4:0]} + 13'd1;
        c16 = {1'b0, hi, lo} + 17'd1;
        c8 = {1'b0, lo} + 9'd1;
        case (mode)
            DCT_MODE13: dct_step = {c13 == 13'd0, c13[12:5], lo[7:5], c13[4:0]};
            DCT_MODE16: dct_step = c16;
            default: dct_step = {c8[8], hi, c8[8] ? hi : c8[7:0]};
        endcase
    endfunction : dct_step

    // timer zero in split behaves as its 8-bit form
    wire [1:0] m0_eff = split ? DCT_MODE8AR : m0;
    wire [16:0] s0 = dct_step(m0_eff, tl0_reg, th0_reg);
    wire [16:0] s1 = dct_step(m1, tl1_reg, th1_reg);
    wire [8:0] sh = {1'b0, th0_reg} + 9'd1;
    // in split the low byte wraps freely, no reload
    wire [7:0] tl0_inc = split ? tl0_reg + 8'd1 : s0[7:0];
    wire ov0 = ev0 && s0[16];
    wire ov1 = ev1 && s1[16];
    wire ovh = evh && sh[8];

    // count bytes: write wins over a same-cycle count
    assign tl0_next = w_tl0 ? wb : (ev0 ? tl0_inc : tl0_reg);
    assign th0_next = w_th0 ? wb : (evh ? sh[7:0] : ((ev0 && !split) ? s0[15:8] : th0_reg));
    assign tl1_next = w_tl1 ? wb : (ev1 ? s1[7:0] : tl1_reg);
    assign th1_next = w_th1 ? wb : (ev1 ? s1[15:8] : th1_reg);

    // flags: hardware set wins over software clear and vector ack
    wire set0 = ov0;
    wire set1 = split ? ovh : ov1;
    wire ack0 = wen && addr_reg == DCT_IRQ_OFS && wb[DCT_ACK0_BIT];
    wire ack1 = wen && addr_reg == DCT_IRQ_OFS && wb[DCT_ACK1_BIT];
    logic [7:0] timer_control_status_reg_w;
    always_comb begin
        timer_control_status_reg_w = w_timer_control_status_reg ? wb : timer_control_status_reg_reg;
        if (ack0) timer_control_status_reg_w[DCT_TF0_BIT] = 1'b0;
        if (ack1) timer_control_status_reg_w[DCT_TF1_BIT] = 1'b0;
        timer_control_status_reg_next = timer_control_status_reg_w;
        if (set0) timer_control_status_reg_next[DCT_TF0_BIT] = 1'b1;
        if (set1) timer_control_status_reg_next[DCT_TF1_BIT] = 1'b1;
    end

    // interrupt requests gated by enables
    assign timer_zero_irq_o = timer_control_status_reg_reg[DCT_TF0_BIT] && irqc_reg[DCT_ET0_BIT];
    assign timer_one_irq_o = timer_control_status_reg_reg[DCT_TF1_BIT] && irqc_reg[DCT_ET1_BIT];
    assign timer_one_overflow_o = ov_reg;

    // bus outputs: registered read data, no wait states, always okay
    assign hrdata_o = rdata_reg;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    // input synchronisers and edge history
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_reg <= 4'hf;
            sync2_reg <= 4'hf;
            prev_reg <= 4'hf;
            ext_s1_reg <= 1'b0;
            ext_s2_reg <= 1'b0;
        end else begin
            sync1_reg <= {ext_irq_input_one_i, ext_irq_input_zero_i,
                          timer_one_count_pin_i, timer_zero_count_pin_i};
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
            ext_s1_reg <= ext_clk_i;
            ext_s2_reg <= ext_s1_reg;
        end
    end

    // bus slave: zero wait states, read data registered at address phase
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_reg <= DCT_IDLE;
            addr_reg <= 8'h00;
            wr_reg <= 1'b0;
        end else begin
            phase_reg <= req ? DCT_DATA : DCT_IDLE;
            if (req) begin
                addr_reg <= {haddr_i[7:2], 2'b00};
                wr_reg <= hwrite_i;
            end
        end
    end

    // read data captured combinationally from current address phase
    wire [7:0] raddr = {haddr_i[7:2], 2'b00};
    always_ff @(posedge clk_i) begin
        if (rst_i) rdata_reg <= 32'h0;
        else if (req && !hwrite_i) rdata_reg <= {24'h0, rsel_now(raddr)};
    end

    // read lookup for the address phase
    function automatic logic [7:0] rsel_now(input logic [7:0] a);
        case (a)
            DCT_TL0_OFS: rsel_now = tl0_next;
            DCT_TH0_OFS: rsel_now = th0_next;
            DCT_TL1_OFS: rsel_now = tl1_next;
            DCT_TH1_OFS: rsel_now = th1_next;
            DCT_TIMER_CONTROL_STATUS_REG_OFS: rsel_now = timer_control_status_reg_next;
            DCT_TIMER_MODE_REG_OFS: rsel_now = wen && addr_reg == DCT_TIMER_MODE_REG_OFS ? wb : timer_mode_reg_reg;
            DCT_CLOCK_CONTROL_REG_OFS: rsel_now = wen && addr_reg == DCT_CLOCK_CONTROL_REG_OFS ? wb : clock_control_reg_reg;
            DCT_IRQ_OFS: rsel_now = {4'h0, (wen && addr_reg == DCT_IRQ_OFS) ? wb[3:0] : irqc_reg[3:0]};
            default: rsel_now = 8'h00;
        endcase
    endfunction : rsel_now

    // timer and control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tl0_reg <= DCT_RESET_VAL;
            th0_reg <= DCT_RESET_VAL;
            tl1_reg <= DCT_RESET_VAL;
            th1_reg <= DCT_RESET_VAL;
            timer_control_status_reg_reg <= DCT_RESET_VAL;
            timer_mode_reg_reg <= DCT_RESET_VAL;
            clock_control_reg_reg <= DCT_RESET_VAL;
            irqc_reg <= DCT_RESET_VAL;
            ov_reg <= 1'b0;
        end else begin
            tl0_reg <= tl0_next;
            th0_reg <= th0_next;
            tl1_reg <= tl1_next;
            th1_reg <= th1_next;
            timer_control_status_reg_reg <= timer_control_status_reg_next;
            if (wen && addr_reg == DCT_TIMER_MODE_REG_OFS) timer_mode_reg_reg <= wb;
            if (wen && addr_reg == DCT_CLOCK_CONTROL_REG_OFS) clock_control_reg_reg <= wb;
            if (wen && addr_reg == DCT_IRQ_OFS) irqc_reg <= {4'h0, wb[3:0]};
            ov_reg <= ov1;
        end
    end

    // checks
    a_ov0_sets: assert property (@(posedge clk_i) disable iff (rst_i)
        ov0 |=> timer_control_status_reg_reg[DCT_TF0_BIT]) else $error("tf0 not set on overflow");
    a_run_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (!tr0 && !w_tl0 && !split) |=> $stable(tl0_reg)) else $error("tl0 moved while stopped");
    a_reload_val: assert property (@(posedge clk_i) disable iff (rst_i)
        (ov1 && m1 == DCT_MODE8AR && !w_tl1) |=> tl1_reg == $past(th1_reg)) else $error("reload wrong");
    a_wr_wins: assert property (@(posedge clk_i) disable iff (rst_i)
        w_tl1 |=> tl1_reg == $past(wb)) else $error("write lost");
    a_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        (ov0 && irqc_reg[DCT_ET0_BIT] && !(wen && addr_reg == DCT_IRQ_OFS)) |=> timer_zero_irq_o)
        else $error("irq not raised");
    a_split_tf1: assert property (@(posedge clk_i) disable iff (rst_i)
        (split && ovh) |=> timer_control_status_reg_reg[DCT_TF1_BIT]) else $error("split high no tf1");
    a_split_stop: assert property (@(posedge clk_i) disable iff (rst_i)
        (split && m1 == DCT_MODESPLIT && !w_tl1) |=> $stable(tl1_reg)) else $error("t1 ran in mode 3");
    a_pin_count: assert property (@(posedge clk_i) disable iff (rst_i)
        (en0 && timer_mode_reg_reg[DCT_CT0_BIT] && !pin0_fall && !w_tl0) |=> $stable(tl0_reg)) else $error("spurious count");
    c_ov0: cover property (@(posedge clk_i) ov0);
    c_ovh: cover property (@(posedge clk_i) ovh);
    c_pin: cover property (@(posedge clk_i) ev0 && pin0_fall);
endmodule : dct_timers
`default_nettype wire

// ---- dct_board_model.sv ----
// board model driving the count pins, gate inputs and external clock
`timescale 1ns/1ps
`default_nettype none
module dct_board_model (
    input wire logic clk_i,
    output logic timer_zero_count_pin_o,
    output logic timer_one_count_pin_o,
    output logic ext_irq_input_zero_o,
    output logic ext_irq_input_one_o,
    output logic ext_clk_o
);
    logic [1:0] div_reg; // divider for the free-running external clock
    // pins idle high, gates low, clock low
    initial begin
        timer_zero_count_pin_o = 1'b1;
        timer_one_count_pin_o = 1'b1;
        ext_irq_input_zero_o = 1'b0;
        ext_irq_input_one_o = 1'b0;
        ext_clk_o = 1'b0;
        div_reg = 2'h0;
    end
    // external oscillator runs free, period six system clocks
    always @(posedge clk_i) begin
        div_reg <= (div_reg == 2'h2) ? 2'h0 : div_reg + 2'h1;
        if (div_reg == 2'h2) begin
            ext_clk_o <= ~ext_clk_o;
        end
    end
    // n falling edges on one pin; low held two clocks, high held five
    task automatic pulse(input int sel, input int n);
        repeat (n) begin
            if (sel == 0) timer_zero_count_pin_o <= 1'b0; else timer_one_count_pin_o <= 1'b0;
            repeat (2) @(posedge clk_i);
            if (sel == 0) timer_zero_count_pin_o <= 1'b1; else timer_one_count_pin_o <= 1'b1;
            repeat (5) @(posedge clk_i);
        end
    endtask : pulse
    // set a gate input level and let the synchroniser settle
    task automatic gate(input int sel, input logic v);
        if (sel == 0) ext_irq_input_zero_o <= v; else ext_irq_input_one_o <= v;
        repeat (4) @(posedge clk_i);
    endtask : gate
endmodule : dct_board_model
`default_nettype wire

// ---- dct_timers_bench.sv ----
// self-checking bench for the dual counter/timer
`timescale 1ns/1ps
`default_nettype none
module dct_timers_bench
    import dct_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0; // clock, reset, bus control
    logic [7:0] haddr = 8'h00; // bus address
    logic [1:0] htrans = 2'h0; // transfer type
    logic [31:0] hwdata = 32'h0, hrdata; // bus data
    logic hready, hresp, irq0, irq1, ovf1; // design outputs
    logic pin0, pin1, g0, g1, xclk; // board lines
    int ovf_cnt = 0; // timer one raw overflow pulses seen
    int bad_count = 0, checked = 0, cycles = 0;
    always #12.5 clk = ~clk;
    dct_timers dct_timers_i (.clk_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
        .hreadyout_o(hready), .hresp_o(hresp), .timer_zero_count_pin_i(pin0), .timer_one_count_pin_i(pin1),
        .ext_irq_input_zero_i(g0), .ext_irq_input_one_i(g1), .ext_clk_i(xclk), .timer_zero_irq_o(irq0),
        .timer_one_irq_o(irq1), .timer_one_overflow_o(ovf1));
    dct_board_model board_i (.clk_i(clk), .timer_zero_count_pin_o(pin0), .timer_one_count_pin_o(pin1),
        .ext_irq_input_zero_o(g0), .ext_irq_input_one_o(g1), .ext_clk_o(xclk));
    // watchdog and overflow pulse monitor
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (ovf1 === 1'b1) ovf_cnt <= ovf_cnt + 1;
        if (cycles == 20000) begin
            bad_count++;
            end_of_test();
        end
    end
    // exact byte comparison
    task automatic eq(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : eq
    // comparison allowing one count of prescaler phase slack
    task automatic near(input logic [7:0] got, input int exp, input string what);
        checked++;
        if (!(got === 8'(exp - 1) || got === 8'(exp) || got === 8'(exp + 1))) begin
            bad_count++;
            $display("mismatch at %0t: %s got %h near %0d", $time, what, got, exp);
        end
    endtask : near
    // one single ahb-lite transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
        hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= DCT_HTRANS_NONSEQ;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= {24'h0, d};
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        r = hrdata[7:0];
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        bus(1'b1, a, d, r);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [7:0] r;
        bus(1'b0, a, 8'h00, r);
        eq(r, exp, what);
        eq({7'h0, hresp}, 8'h00, "okay response");
    endtask : rd
    // reset values, byte access and an unmapped place
    task automatic t_reset();
        for (int a = 0; a <= 32; a += 4) rd(8'(a), DCT_RESET_VAL, "reset value");
        wr(DCT_TL0_OFS, 8'ha5);
        wr(DCT_TH0_OFS, 8'h5a);
        wr(8'h20, 8'hff);
        rd(DCT_TL0_OFS, 8'ha5, "low byte");
        rd(DCT_TH0_OFS, 8'h5a, "high byte");
        rd(8'h20, 8'h00, "unmapped");
    endtask : t_reset
    // 13-bit counter wrap, flag, interrupt enable and vector ack
    task automatic t_mode13();
        wr(DCT_TH0_OFS, 8'hff);
        wr(DCT_TL0_OFS, 8'h1e);
        wr(DCT_TIMER_MODE_REG_OFS, 8'h04);
        wr(DCT_TIMER_CONTROL_STATUS_REG_OFS, 8'h10);
        rd(DCT_TL0_OFS, 8'h1e, "run keeps count");
        board_i.pulse(0, 1);
        rd(DCT_TL0_OFS, 8'h1f, "13-bit low");
        board_i.pulse(0, 1);
        rd(DCT_TL0_OFS, 8'h00, "13-bit wrap low");
        rd(DCT_TH0_OFS, 8'h00, "13-bit wrap high");
        rd(DCT_TIMER_CONTROL_STATUS_REG_OFS, 8'h30, "13-bit flag");
        eq({7'h0, irq0}, 8'h00, "irq masked");
        wr(DCT_IRQ_OFS, 8'h01);
        @(posedge clk);
        eq({7'h0, irq0}, 8'h01, "irq enabled");
        wr(DCT_IRQ_OFS, 8'h11);
        rd(DCT_TIMER_CONTROL_STATUS_REG_OFS, 8'h10, "vector ack");
        eq({7'h0, irq0}, 8'h00, "irq after ack");
        wr(DCT_TIMER_CONTROL_STATUS_REG_OFS, 8'h00);
    endtask : t_mode13
    // 16-bit counter gated by input zero, active high
    task automatic t_gate16();
        wr(DCT_TH0_OFS, 8'hff);
        wr(DCT_TL0_OFS, 8'hfe);
        wr(DCT_IRQ_OFS, 8'h05);
        wr(DCT_TIMER_MODE_REG_OFS, 8'h0d);
        wr(DCT_TIMER_CONTROL_STATUS_REG_OFS, 8'h10);
        board_i.pulse(0, 1);
        rd(DCT_TL0_OFS, 8'hfe, "gate closed");
        board_i.gate(0, 1'b1);
        board_i.pulse(0, 1);
        rd(DCT_TL0_OFS, 8'hff, "gate open");
        board_i.pulse(0, 1);
        rd(DCT_TH0_OFS, 8'h00, "16-bit wrap");
        rd(DCT_TIMER_CONTROL_STATUS_REG_OFS, 8'h30, "16-bit flag");
        eq({7'h0, irq0}, 8'h01, "irq on 16-bit wrap");
        wr(DCT_TIMER_CONTROL_STATUS_REG_OFS, 8'h10);
        rd(DCT_TIMER_CONTROL_STATUS_REG_OFS, 8'h10, "software clear");
        wr(DCT_TIMER_CONTROL_STATUS_REG_OFS, 8'h00);
        board_i.pulse(0, 1);
        rd(DCT_TL0_OFS, 8'h00, "run bit off");
        board_i.gate(0, 1'b0);
    endtask : t_gate16
    // timer one auto-reload counter gated by input one, active low
    task automatic t_reload();
        wr(DCT_TH1_OFS, 8'hf0);
        wr(DCT_TL1_OFS, 8'hfe);
        wr(DCT_IRQ_OFS, 8'h02);
        wr(DCT_TIMER_MODE_REG_OFS, 8'he0);
        wr(DCT_TIMER_CONTROL_STATUS_REG_OFS, 8'h40);
        board_i.gate(1, 1'b1);
        board_i.pulse(1, 1);
        rd(DCT_TL1_OFS, 8'hfe, "gate one closed");
        board_i.gate(1, 1'b0);
        board_i.pulse(1, 2);
        rd(DCT_TL1_OFS, 8'hf0, "reloaded");
        rd(DCT_TH1_OFS, 8'hf0, "reload kept");
        rd(DCT_TIMER_CONTROL_STATUS_REG_OFS, 8'hc0, "reload flag");
        eq({7'h0, irq1}, 8'h01, "irq one");
        eq(8'(ovf_cnt), 8'h01, "raw overflow one");
        board_i.pulse(1, 1);
        rd(DCT_TL1_OFS, 8'hf1, "after reload");
        wr(DCT_TIMER_CONTROL_STATUS_REG_OFS, 8'h00);
    endtask : t_reload
    // split mode: low byte by pin, high byte under run one, timer one per mode
    task automatic t_split();
        int n0;
        wr(DCT_TL1_OFS, 8'h55);
        wr(DCT_TL0_OFS, 8'hff);
        wr(DCT_TH0_OFS, 8'hfe);
        wr(DCT_CLOCK_CONTROL_REG_OFS, 8'h04);
        wr(DCT_TIMER_MODE_REG_OFS, 8'h37);
        wr(DCT_TIMER_CONTROL_STATUS_REG_OFS, 8'h50);
        repeat (10) @(posedge clk);
        rd(DCT_TIMER_CONTROL_STATUS_REG_OFS, 8'hd0, "high byte sets flag one");
        board_i.pulse(0, 1);
        rd(DCT_TL0_OFS, 8'h00, "split low wrap");
        rd(DCT_TIMER_CONTROL_STATUS_REG_OFS, 8'hf0, "split low flag");
        rd(DCT_TL1_OFS, 8'h55, "timer one stopped");
        wr(DCT_TIMER_CONTROL_STATUS_REG_OFS, 8'h10);
        wr(DCT_TH1_OFS, 8'hff);
        wr(DCT_TL1_OFS, 8'hf0);
        wr(DCT_CLOCK_CONTROL_REG_OFS, 8'h0c);
        n0 = ovf_cnt;
        wr(DCT_TIMER_MODE_REG_OFS, 8'h57);
        repeat (40) @(posedge clk);
        rd(DCT_TIMER_CONTROL_STATUS_REG_OFS, 8'h10, "no flag one");
        rd(DCT_TH1_OFS, 8'h00, "timer one internal");
        eq(8'(ovf_cnt - n0), 8'h01, "raw overflow");
        wr(DCT_TIMER_CONTROL_STATUS_REG_OFS, 8'h00);
        wr(DCT_TIMER_MODE_REG_OFS, 8'h00);
    endtask : t_split
    // every prescale code and the direct system clock over 480 cycles
    task automatic t_prescale();
        logic [7:0] ck[5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04};
        int ex[5] = '{40, 120, 10, 10, 224};
        logic [7:0] r;
        for (int i = 0; i < 5; i++) begin
            wr(DCT_CLOCK_CONTROL_REG_OFS, ck[i]);
            wr(DCT_TIMER_MODE_REG_OFS, 8'h01);
            wr(DCT_TL0_OFS, 8'h00);
            wr(DCT_TH0_OFS, 8'h00);
            wr(DCT_TIMER_CONTROL_STATUS_REG_OFS, 8'h10);
            repeat (478) @(posedge clk);
            wr(DCT_TIMER_CONTROL_STATUS_REG_OFS, 8'h00);
            bus(1'b0, DCT_TL0_OFS, 8'h00, r);
            near(r, ex[i], "prescaled count");
        end
    endtask : t_prescale
    // closing report
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test
    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_mode13();
        t_gate16();
        t_reload();
        t_split();
        t_prescale();
        end_of_test();
    end
endmodule : dct_timers_bench
`default_nettype wire
